// [hdl/rtc_regbank.sv]
// Clock/calendar register bank with oscillator source select and run monitor
//
// Overview of operation
// - The clock, control, trim, unlock, alarm and stamp registers form one byte map at 00h-1Fh.
// - Unimplemented bit positions hold no storage and writes to them do nothing.
// - The hour-format bit of each alarm hour register is read-only and mirrors the time hours one.
// - The polarity bit of the second alarm weekday register is read-only and mirrors the first.
// - The crystal amplifier runs only while the start bit is one, which the host sets.
// - The time source is either the crystal oscillator or an external clock on the crystal input.
// - Unimplemented bits always read as zero.
// - The external select enables the clock input, the start bit the crystal; host stops first.
// - The running flag sets after 32 source cycles and clears after the failure timeout.
`timescale 1ns/1ps
`default_nettype none
module rtc_regbank
	import rtc_pkg::*;
#(
	parameter int OSC_FAIL_CYC = RTC_OSC_FAIL_CYC
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire rtc_req_t req_i,
	input wire rtc_stamp_t stamp_i,
	input wire logic crystal_in_pin_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic unlock_strobe_o,
	output logic [7:0] unlock_data_o,
	output logic crystal_amp_en_o,
	output logic ext_clk_en_o,
	output logic oscillator_running_flag_o
);

	localparam int FW = $clog2(OSC_FAIL_CYC + 1);

	if (OSC_FAIL_CYC < 2) begin : g_chk
		$error("rtc_regbank: OSC_FAIL_CYC must be at least 2");
	end

	logic oscillator_start_bit_reg;
	logic external_clock_select_reg;
	logic hour_fmt_reg;
	logic alarm_output_polarity_reg;
	logic mem_we;
	logic [7:0] mem_q;
	logic rd_d1_reg;
	logic [4:0] rd_addr_d1_reg;
	logic [4:0] rd_addr_d2_reg;
	logic [7:0] rd_byte;
	logic xin_d_reg;
	logic xin_rise;
	logic src_en;
	logic [4:0] edge_cnt_reg;
	logic [FW-1:0] idle_cnt_reg;
	logic idle_timeout;
	rtc_osc_state_t osc_state_reg;
	rtc_osc_state_t osc_state_next;

	// Only the writable map is stored; stamps and unlock port take no write
	assign mem_we = req_i.wr && (rtc_wmask(req_i.addr) != 8'h00);

	rtc_regmem #(
		.AW(RTC_AW),
		.DW(RTC_DW)
	) u_mem (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.we_i(mem_we),
		.waddr_i(req_i.addr),
		.wdata_i(req_i.wdata & rtc_wmask(req_i.addr)),
		.raddr_i(req_i.addr),
		.rdata_o(mem_q)
	);

	// Live copies of bits that other logic or aliases need
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			oscillator_start_bit_reg <= 1'b0;
			external_clock_select_reg <= 1'b0;
			hour_fmt_reg <= 1'b0;
			alarm_output_polarity_reg <= 1'b0;
		end else if (req_i.wr) begin
			case (req_i.addr)
				RTC_A_TIME_SECONDS: oscillator_start_bit_reg <= req_i.wdata[RTC_B_OSC_START];
				RTC_A_OUT_CLK_CFG: external_clock_select_reg <= req_i.wdata[RTC_B_EXT_CLK_SEL];
				RTC_A_TIME_HOURS: hour_fmt_reg <= req_i.wdata[RTC_B_HOUR_FMT];
				RTC_A_ALM0_WKDAY: alarm_output_polarity_reg <= req_i.wdata[RTC_B_ALM_POL];
				default: ;
			endcase
		end
	end

	// Unlock port is not stored; each write is passed on as a strobe
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			unlock_strobe_o <= 1'b0;
			unlock_data_o <= RTC_RESET_BYTE;
		end else begin
			unlock_strobe_o <= req_i.wr && (req_i.addr == RTC_A_UNLOCK_PORT);
			if (req_i.wr && (req_i.addr == RTC_A_UNLOCK_PORT)) begin
				unlock_data_o <= req_i.wdata;
			end
		end
	end

	// Read pipeline: memory stage, then overlay stage
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rd_d1_reg <= 1'b0;
			rd_addr_d1_reg <= RTC_ADDR_FIRST;
			rd_addr_d2_reg <= RTC_ADDR_FIRST;
		end else begin
			rd_d1_reg <= req_i.rd;
			rd_addr_d1_reg <= req_i.addr;
			rd_addr_d2_reg <= rd_addr_d1_reg;
		end
	end

	// Compose the read byte from storage, stamps and mirrored bits
	always_comb begin
		rd_byte = mem_q;
		if (rd_addr_d1_reg >= RTC_A_STAMP_FIRST) begin
			rd_byte = stamp_i[8*3'(rd_addr_d1_reg - RTC_A_STAMP_FIRST) +: 8];
		end
		case (rd_addr_d1_reg)
			RTC_A_WEEKDAY_PWR: rd_byte[RTC_B_OSC_RUNNING] = oscillator_running_flag_o;
			RTC_A_ALM0_HOURS, RTC_A_ALM1_HOURS: rd_byte[RTC_B_HOUR_FMT] = hour_fmt_reg;
			RTC_A_ALM1_WKDAY: rd_byte[RTC_B_ALM_POL] = alarm_output_polarity_reg;
			default: ;
		endcase
		rd_byte = rd_byte & rtc_rmask(rd_addr_d1_reg);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= RTC_RESET_BYTE;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= rd_d1_reg;
			rd_data_o <= rd_d1_reg ? rd_byte : RTC_RESET_BYTE;
		end
	end

	// Source enables: crystal needs start bit and no external select
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			crystal_amp_en_o <= 1'b0;
			ext_clk_en_o <= 1'b0;
		end else begin
			crystal_amp_en_o <= oscillator_start_bit_reg && !external_clock_select_reg;
			ext_clk_en_o <= external_clock_select_reg;
		end
	end

	// Input is taken as synchronous, so one flop suffices for the edge
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			xin_d_reg <= 1'b0;
		end else begin
			xin_d_reg <= crystal_in_pin_i;
		end
	end

	assign src_en = crystal_amp_en_o || ext_clk_en_o;
	assign xin_rise = src_en && crystal_in_pin_i && !xin_d_reg;
	assign idle_timeout = (idle_cnt_reg == FW'(OSC_FAIL_CYC));

	// Silence counter; a disabled source is simply never seen again
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			idle_cnt_reg <= '0;
		end else if (xin_rise || osc_state_reg == RTC_OSC_OFF) begin
			idle_cnt_reg <= '0;
		end else if (!idle_timeout) begin
			idle_cnt_reg <= idle_cnt_reg + FW'(1);
		end
	end

	// Start-up edge counter
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			edge_cnt_reg <= 5'h00;
		end else if (idle_timeout || osc_state_next != RTC_OSC_START) begin
			edge_cnt_reg <= 5'h00;
		end else if (xin_rise) begin
			edge_cnt_reg <= edge_cnt_reg + 5'h01;
		end
	end

	// Monitor state machine
	always_comb begin
		osc_state_next = osc_state_reg;
		case (osc_state_reg)
			RTC_OSC_OFF: begin
				if (xin_rise) begin
					osc_state_next = RTC_OSC_START;
				end
			end
			RTC_OSC_START: begin
				if (idle_timeout) begin
					osc_state_next = RTC_OSC_OFF;
				end else if (xin_rise && edge_cnt_reg == RTC_OSC_START_EDGES) begin
					osc_state_next = RTC_OSC_RUN;
				end
			end
			RTC_OSC_RUN: begin
				if (idle_timeout) begin
					osc_state_next = RTC_OSC_OFF;
				end
			end
			default: osc_state_next = RTC_OSC_OFF;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			osc_state_reg <= RTC_OSC_OFF;
			oscillator_running_flag_o <= 1'b0;
		end else begin
			osc_state_reg <= osc_state_next;
			oscillator_running_flag_o <= (osc_state_next == RTC_OSC_RUN);
		end
	end

	// Checks
	property p_read_latency;
		@(posedge ref_clk_i) disable iff (sys_rst_i) req_i.rd |-> ##2 rd_valid_o;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer late");

	property p_unimpl_zero;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			rd_valid_o |-> ((rd_data_o & ~rtc_rmask(rd_addr_d2_reg)) == 8'h00);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read one");

	property p_gap_zero;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			req_i.rd && (req_i.addr == RTC_A_GAP_A || req_i.addr == RTC_A_GAP_B)
			|-> ##2 rd_data_o == 8'h00;
	endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("gap address read nonzero");

	// Looks at raw storage, before the read mask could hide a stored bit
	property p_no_store;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			rd_d1_reg && rd_addr_d1_reg == RTC_A_ALM0_MONTH |-> mem_q[7:5] == 3'h0;
	endproperty
	a_no_store: assert property (p_no_store) else $error("unimplemented bit stored");

	property p_fmt_mirror;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			rd_valid_o && (rd_addr_d2_reg == RTC_A_ALM0_HOURS || rd_addr_d2_reg == RTC_A_ALM1_HOURS)
			|-> rd_data_o[RTC_B_HOUR_FMT] == $past(hour_fmt_reg);
	endproperty
	a_fmt_mirror: assert property (p_fmt_mirror) else $error("alarm hour format not mirrored");

	property p_pol_mirror;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			rd_valid_o && rd_addr_d2_reg == RTC_A_ALM1_WKDAY
			|-> rd_data_o[RTC_B_ALM_POL] == $past(alarm_output_polarity_reg);
	endproperty
	a_pol_mirror: assert property (p_pol_mirror) else $error("alarm polarity not mirrored");

	property p_xtal_needs_start;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			!oscillator_start_bit_reg |=> !crystal_amp_en_o;
	endproperty
	a_xtal_needs_start: assert property (p_xtal_needs_start) else $error("crystal on without start");

	property p_one_source;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			!(crystal_amp_en_o && ext_clk_en_o) && (ext_clk_en_o == $past(external_clock_select_reg));
	endproperty
	a_one_source: assert property (p_one_source) else $error("clock source select wrong");

	property p_disabled_no_count;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			!src_en && crystal_in_pin_i && !xin_d_reg |=> $stable(edge_cnt_reg) || edge_cnt_reg == 5'h00;
	endproperty
	a_disabled_no_count: assert property (p_disabled_no_count) else $error("disabled source counted");

	property p_run_after_32;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			$rose(oscillator_running_flag_o) |-> $past(edge_cnt_reg) == RTC_OSC_START_EDGES && $past(xin_rise);
	endproperty
	a_run_after_32: assert property (p_run_after_32) else $error("running set early");

	property p_fail_clears;
		@(posedge ref_clk_i) disable iff (sys_rst_i) idle_timeout |=> !oscillator_running_flag_o;
	endproperty
	a_fail_clears: assert property (p_fail_clears) else $error("running not cleared");

	c_run_rise: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(oscillator_running_flag_o));
	c_run_fall: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(oscillator_running_flag_o));
	c_alm_hour_read: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		rd_valid_o && rd_addr_d2_reg == RTC_A_ALM1_HOURS && rd_data_o[RTC_B_HOUR_FMT]);
	c_unlock: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) unlock_strobe_o);

endmodule
`default_nettype wire

// [hdl/rtc_pkg.sv]
// Shared constants, types and access masks of the clock/calendar register bank
package rtc_pkg;

	// Map geometry
	localparam int RTC_AW = 5;
	localparam int RTC_DW = 8;
	localparam logic [4:0] RTC_ADDR_FIRST = 5'h00;
	localparam logic [4:0] RTC_ADDR_LAST = 5'h1f;

	// Register offsets
	localparam logic [4:0] RTC_A_TIME_SECONDS = 5'h00;
	localparam logic [4:0] RTC_A_TIME_MINUTES = 5'h01;
	localparam logic [4:0] RTC_A_TIME_HOURS = 5'h02;
	localparam logic [4:0] RTC_A_WEEKDAY_PWR = 5'h03;
	localparam logic [4:0] RTC_A_CAL_DAY = 5'h04;
	localparam logic [4:0] RTC_A_CAL_MONTH = 5'h05;
	localparam logic [4:0] RTC_A_CAL_YEAR = 5'h06;
	localparam logic [4:0] RTC_A_OUT_CLK_CFG = 5'h07;
	localparam logic [4:0] RTC_A_DIGITAL_TRIM = 5'h08;
	localparam logic [4:0] RTC_A_UNLOCK_PORT = 5'h09;
	localparam logic [4:0] RTC_A_ALM0_SECONDS = 5'h0a;
	localparam logic [4:0] RTC_A_ALM0_MINUTES = 5'h0b;
	localparam logic [4:0] RTC_A_ALM0_HOURS = 5'h0c;
	localparam logic [4:0] RTC_A_ALM0_WKDAY = 5'h0d;
	localparam logic [4:0] RTC_A_ALM0_DAY = 5'h0e;
	localparam logic [4:0] RTC_A_ALM0_MONTH = 5'h0f;
	localparam logic [4:0] RTC_A_GAP_A = 5'h10;
	localparam logic [4:0] RTC_A_ALM1_SECONDS = 5'h11;
	localparam logic [4:0] RTC_A_ALM1_MINUTES = 5'h12;
	localparam logic [4:0] RTC_A_ALM1_HOURS = 5'h13;
	localparam logic [4:0] RTC_A_ALM1_WKDAY = 5'h14;
	localparam logic [4:0] RTC_A_ALM1_DAY = 5'h15;
	localparam logic [4:0] RTC_A_ALM1_MONTH = 5'h16;
	localparam logic [4:0] RTC_A_GAP_B = 5'h17;
	localparam logic [4:0] RTC_A_STAMP_FIRST = 5'h18;

	// Field positions
	localparam int RTC_B_OSC_START = 7;
	localparam int RTC_B_HOUR_FMT = 6;
	localparam int RTC_B_OSC_RUNNING = 5;
	localparam int RTC_B_EXT_CLK_SEL = 3;
	localparam int RTC_B_ALM_POL = 7;

	// Reset value of all stored bits
	localparam logic [7:0] RTC_RESET_BYTE = 8'h00;

	// Oscillator monitor
	localparam logic [4:0] RTC_OSC_START_EDGES = 5'h1f;
	localparam int RTC_CLK_PERIOD_NS = 8;
	localparam int RTC_OSC_FAIL_TIME_NS = 1000000;
	localparam int RTC_OSC_FAIL_CYC = RTC_OSC_FAIL_TIME_NS / RTC_CLK_PERIOD_NS;

	// Oscillator monitor states, Gray along off -> start -> run
	typedef enum logic [1:0] {
		RTC_OSC_OFF = 2'b00,
		RTC_OSC_START = 2'b01,
		RTC_OSC_RUN = 2'b11
	} rtc_osc_state_t;

	// Register access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} rtc_req_t;

	// Power-fail stamp bytes, in reverse map order (dn_minutes at 18h, up_month_wday at 1Fh)
	typedef struct packed {
		logic [7:0] up_month_wday;
		logic [7:0] up_day;
		logic [7:0] up_hours;
		logic [7:0] up_minutes;
		logic [7:0] dn_month_wday;
		logic [7:0] dn_day;
		logic [7:0] dn_hours;
		logic [7:0] dn_minutes;
	} rtc_stamp_t;

	// Bits that host writes store
	function automatic logic [7:0] rtc_wmask(input logic [4:0] a);
		case (a)
			5'h00, 5'h06, 5'h07, 5'h08, 5'h0d: rtc_wmask = 8'hff;
			5'h01, 5'h02, 5'h0a, 5'h0b, 5'h11, 5'h12, 5'h14: rtc_wmask = 8'h7f;
			5'h03, 5'h0f, 5'h16: rtc_wmask = 8'h1f;
			5'h04, 5'h05, 5'h0c, 5'h0e, 5'h13, 5'h15: rtc_wmask = 8'h3f;
			default: rtc_wmask = 8'h00;
		endcase
	endfunction

	// Bits that read back as anything but zero
	function automatic logic [7:0] rtc_rmask(input logic [4:0] a);
		case (a)
			5'h00, 5'h06, 5'h07, 5'h08, 5'h0d, 5'h14, 5'h1b, 5'h1f: rtc_rmask = 8'hff;
			5'h01, 5'h02, 5'h0a, 5'h0b, 5'h0c, 5'h11, 5'h12, 5'h13: rtc_rmask = 8'h7f;
			5'h18, 5'h19, 5'h1c, 5'h1d: rtc_rmask = 8'h7f;
			5'h03, 5'h04, 5'h05, 5'h0e, 5'h15, 5'h1a, 5'h1e: rtc_rmask = 8'h3f;
			5'h0f, 5'h16: rtc_rmask = 8'h1f;
			default: rtc_rmask = 8'h00;
		endcase
	endfunction

endpackage

// [hdl/rtc_regmem.sv]
// Byte storage for the writable part of the register map, registered read
`timescale 1ns/1ps
`default_nettype none
module rtc_regmem #(
	parameter int AW = 5,
	parameter int DW = 8
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] mem_reg [2**AW];

	if (AW < 1 || DW < 1) begin : g_chk
		$error("rtc_regmem: AW and DW must be at least 1");
	end

	// Storage cleared on reset so every stored bit starts at zero
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	// Read every cycle; old data on a same-address write
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem_reg[raddr_i];
		end
	end

endmodule
`default_nettype wire

// [tb/rtc_host_model.sv]
// Register-port host model issuing single-byte read and write requests
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model
	import rtc_pkg::*;
(
	input wire logic ref_clk_i,
	output var rtc_req_t req_o
);
	logic [31:0] seed = 32'h0000_1976;

	initial req_o = '0;

	// Xorshift source shared by the bench, fixed start for repeatable runs
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Idle cycles carry junk address and data, so a stale value never passes for a request
	task automatic idle();
		logic [31:0] r;
		r = rnd();
		@(negedge ref_clk_i);
		req_o <= {2'b00, r[12:0]};
	endtask

	// One request per call, launched on the falling edge; calls back to back give a pipeline
	task automatic issue(input logic rd, input logic wr, input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		if (wr && (a == RTC_A_GAP_A || a == RTC_A_GAP_B))
			req_o <= {rd, 1'b0, a, d};
		else
			req_o <= {rd, wr, a, d};
	endtask
endmodule
`default_nettype wire

// [tb/rtc_regbank_tb.sv]
// Self-checking bench for the clock/calendar register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("[FAIL] %s expected %h seen %h", nm, exp, got); \
		end \
	end
module rtc_regbank_tb
	import rtc_pkg::*;
;
	localparam int FAIL_CYC = 50;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	rtc_req_t req;
	rtc_stamp_t stamp = '0;
	logic xtal = 1'b0;
	logic [7:0] rd_data, unl_data;
	logic rd_valid, unl_stb, amp_en, ext_en, run_flag;
	logic [7:0] mem [32];
	logic exp_run = 1'b0;
	int error_cnt = 0;
	int comparisons = 0;
	// Write address, data, then the address read back
	logic [17:0] dir_tab [12] = '{{5'h02, 8'hc0, 5'h0c}, {5'h0d, 8'h80, 5'h14},
		{5'h0d, 8'h00, 5'h14}, {5'h02, 8'h40, 5'h13}, {5'h14, 8'hff, 5'h14},
		{5'h0c, 8'hff, 5'h0c}, {5'h09, 8'ha5, 5'h09}, {5'h01, 8'hff, 5'h01},
		{5'h03, 8'hff, 5'h03}, {5'h1b, 8'hff, 5'h1b}, {5'h05, 8'hff, 5'h05},
		{5'h0f, 8'hff, 5'h0f}};

	always #4 ref_clk_i = ~ref_clk_i;

	rtc_host_model host (.ref_clk_i(ref_clk_i), .req_o(req));

	rtc_regbank #(.OSC_FAIL_CYC(FAIL_CYC)) uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.req_i(req), .stamp_i(stamp), .crystal_in_pin_i(xtal), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid), .unlock_strobe_o(unl_stb), .unlock_data_o(unl_data),
		.crystal_amp_en_o(amp_en), .ext_clk_en_o(ext_en), .oscillator_running_flag_o(run_flag));

	// Bits a write keeps, per address
	function automatic logic [7:0] wmask(input logic [4:0] a);
		case (a)
			5'h00, 5'h06, 5'h07, 5'h08, 5'h0d: return 8'hff;
			5'h01, 5'h02, 5'h0a, 5'h0b, 5'h11, 5'h12, 5'h14: return 8'h7f;
			5'h03, 5'h0f, 5'h16: return 8'h1f;
			5'h04, 5'h05, 5'h0c, 5'h0e, 5'h13, 5'h15: return 8'h3f;
			default: return 8'h00;
		endcase
	endfunction

	// Expected read byte: stored bits, mirrors and live stamp bytes
	function automatic logic [7:0] exp_rd(input logic [4:0] a);
		logic [7:0] v;
		logic [7:0] sb;
		v = mem[a];
		sb = stamp[8 * (int'(a) % 8) +: 8];
		case (a)
			5'h03: v[5] = exp_run;
			5'h0c, 5'h13: v[6] = mem[2][6];
			5'h14: v[7] = mem[13][7];
			5'h18, 5'h19, 5'h1c, 5'h1d: v = sb & 8'h7f;
			5'h1a, 5'h1e: v = sb & 8'h3f;
			5'h1b, 5'h1f: v = sb;
			default: v = v;
		endcase
		return v;
	endfunction

	task automatic do_reset();
		@(negedge ref_clk_i);
		sys_rst_i <= 1'b1;
		repeat (8) @(negedge ref_clk_i);
		sys_rst_i <= 1'b0;
		foreach (mem[i]) mem[i] = 8'h00;
		exp_run = 1'b0;
	endtask

	// Reserved gaps are never sent by the host, so nothing is stored for them
	task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
		host.issue(1'b0, 1'b1, a, d);
		host.idle();
		if (a != RTC_A_GAP_A && a != RTC_A_GAP_B)
			mem[a] = d & wmask(a);
	endtask

	// Read with a bounded wait for the valid pulse
	task automatic reg_rd(input logic [4:0] a, output logic [7:0] q);
		int n;
		host.issue(1'b1, 1'b0, a, 8'h00);
		n = 0;
		do begin
			host.idle();
			n++;
		end while (rd_valid !== 1'b1 && n < 6);
		`CHK("read latency", 2, n)
		q = rd_data;
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			@(negedge ref_clk_i);
			xtal <= 1'b1;
			@(negedge ref_clk_i);
			xtal <= 1'b0;
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		error_cnt++;
		$display("[FAIL] watchdog expected finish seen timeout");
		print_verdict();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] q;
		do_reset();
		stamp = {host.rnd(), host.rnd()};
		for (int i = 0; i < 32; i++) begin
			reg_rd(5'(i), q);
			`CHK("reset map", exp_rd(5'(i)), q)
		end
		$display("test reset_map done");
		// Random traffic with live stamps; pin still, so no edges
		for (int i = 0; i < 300; i++) begin
			r = host.rnd();
			stamp = {host.rnd(), host.rnd()};
			reg_wr(r[4:0], r[15:8]);
			reg_rd(r[4:0], q);
			`CHK("random read", exp_rd(r[4:0]), q)
			`CHK("crystal enable", mem[0][7] & ~mem[7][3], amp_en)
			`CHK("external enable", mem[7][3], ext_en)
		end
		$display("test random done");
		for (int i = 0; i < 12; i++) begin
			reg_wr(dir_tab[i][17:13], dir_tab[i][12:5]);
			reg_rd(dir_tab[i][4:0], q);
			`CHK("mirror or mask", exp_rd(dir_tab[i][4:0]), q)
		end
		$display("test mirrors done");
		// Read in the cycle after a write sees the new byte
		host.issue(1'b0, 1'b1, 5'h08, 8'h5a);
		mem[8] = 8'h5a;
		reg_rd(5'h08, q);
		`CHK("write then read", 8'h5a, q)
		host.issue(1'b0, 1'b1, RTC_A_UNLOCK_PORT, 8'h3c);
		host.idle();
		`CHK("unlock strobe", 1'b1, unl_stb)
		`CHK("unlock data", 8'h3c, unl_data)
		host.idle();
		`CHK("unlock strobe end", 1'b0, unl_stb)
		$display("test pipeline_unlock done");
		// Both sources off: edges are ignored
		reg_wr(5'h00, 8'h00);
		reg_wr(5'h07, 8'h00);
		pulses(40);
		repeat (4) @(negedge ref_clk_i);
		`CHK("off flag", 1'b0, run_flag)
		reg_wr(5'h00, 8'h80);
		pulses(31);
		repeat (4) @(negedge ref_clk_i);
		`CHK("amp on", 1'b1, amp_en)
		`CHK("flag at 31", 1'b0, run_flag)
		pulses(1);
		repeat (4) @(negedge ref_clk_i);
		exp_run = 1'b1;
		`CHK("flag at 32", 1'b1, run_flag)
		reg_rd(5'h03, q);
		`CHK("flag bit", exp_rd(5'h03), q)
		// Host stops the crystal and waits for the flag before loading time
		reg_wr(5'h00, 8'h00);
		`CHK("flag holds", 1'b1, run_flag)
		repeat (FAIL_CYC + 20) @(negedge ref_clk_i);
		exp_run = 1'b0;
		`CHK("flag timeout", 1'b0, run_flag)
		reg_wr(5'h00, 8'h12);
		reg_wr(5'h07, 8'h08);
		pulses(32);
		repeat (20) @(negedge ref_clk_i);
		`CHK("ext flag", 1'b1, run_flag)
		`CHK("ext path", 2'b01, {amp_en, ext_en})
		$display("test oscillator done");
		reg_wr(5'h00, 8'h80);
		do_reset();
		reg_rd(5'h07, q);
		`CHK("second reset", 8'h00, q)
		`CHK("enables cleared", 3'b000, {amp_en, ext_en, run_flag})
		$display("test second_reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
